// ---- hw/lpc_defs.vh ----
`ifndef LPC_DEFS_VH
`define LPC_DEFS_VH

// ==========================================================
// Register map
`define LPC_AW              8
`define LPC_DW              16
`define LPC_ADDR_FRAMING    8'h42
`define LPC_ADDR_CLK_TIMING 8'h44
`define LPC_ADDR_LOOP_ALARM 8'h46
`define LPC_RESET_VALUE     16'h0000
`define LPC_READ_IDLE       16'h0000

// Writable bits of each register
`define LPC_MASK_FRAMING    16'h0038
`define LPC_MASK_CLK_TIMING 16'h36FF
`define LPC_MASK_LOOP_ALARM 16'h07FF

// ==========================================================
// Field positions
`define LPC_FM_LO           3
`define LPC_FM_HI           5
`define LPC_RX_CLK_SEL      13
`define LPC_RX_FRM_SEL      12
`define LPC_TX_CLK_SEL      10
`define LPC_TX_FRM_SEL      9
`define LPC_REF_SRC_HI      7
`define LPC_REF_SRC_LO      6
`define LPC_TIMER_REF       5
`define LPC_LOOP_TIME       4
`define LPC_CLOCK_RATE_ADAPTER_DIS        3
`define LPC_RX_FR_TIMING    2
`define LPC_TX_FR_TIMING    1
`define LPC_TX_LN_TIMING    0
`define LPC_LBM_HI          10
`define LPC_LBM_LO          8
`define LPC_GPB_HI          7
`define LPC_GPB_LO          4
`define LPC_GPA_HI          3
`define LPC_GPA_LO          0

// ==========================================================
// Framing codes
`define LPC_FM_DS3_CBIT     3'h0
`define LPC_FM_DS3_M23      3'h1
`define LPC_FM_E3_G751      3'h2
`define LPC_FM_E3_G832      3'h3
`define LPC_FM_DS3_UNFR     3'h4
`define LPC_FM_UNDEF_A      3'h5
`define LPC_FM_E3_UNFR      3'h6
`define LPC_FM_UNDEF_B      3'h7

// Port reference source codes
`define LPC_REF_RX_FRAMER   2'h2
`define LPC_REF_TX_FRAMER   2'h3

// Loopback codes
`define LPC_LB_NONE         3'h0
`define LPC_LB_ANALOG       3'h1
`define LPC_LB_LINE         3'h2
`define LPC_LB_PAYLOAD      3'h3
`define LPC_LB_DIAG_A       3'h4
`define LPC_LB_DIAG_B       3'h5
`define LPC_LB_LINE_DIAG    3'h6
`define LPC_LB_DIAG_C       3'h7

// Transmit clock source codes
`define LPC_TXSRC_PIN       2'h0
`define LPC_TXSRC_RX_LINE   2'h1
`define LPC_TXSRC_RECOVER   2'h2
`define LPC_TXSRC_CLOCK_RATE_ADAPTER      2'h3

// Alarm vector bit positions
`define LPC_AL_LOS          0
`define LPC_AL_OOF          1
`define LPC_AL_LOF          2
`define LPC_AL_AIS          3
`define LPC_AL_RAI          4
`define LPC_AL_IDLE         5
`define LPC_AL_W            6

`endif

// ---- hw/lpc_port_cfg.v ----
`timescale 1ns/1ps
`include "lpc_defs.vh"

module lpc_port_cfg (
   core_clk,
   rst_b,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   rx_gated_clock,
   rx_clock_output,
   rx_data_enable,
   rx_start_of_frame_out,
   tx_gated_clock,
   tx_clock_output,
   tx_data_enable,
   tx_start_of_frame_out,
   rx_framer_ref,
   tx_framer_ref,
   global_ref_8k,
   rx_line_clock_pin,
   liu_recovered_clk,
   liu_enabled,
   clock_rate_adapter,
   tx_clock_input_pin,
   alarm_status,
   general_pin_one_en,
   general_pin_two_en,
   framing_select,
   framing_undefined,
   rx_clk_pin,
   rx_frame_pin,
   tx_clk_pin,
   tx_frame_pin,
   port_ref_8k,
   port_ref_valid,
   chip_ref_candidate,
   timer_ref_8k,
   tx_clk_source,
   tx_internal_clk,
   rx_framer_io_timing,
   tx_framer_io_timing,
   tx_line_io_timing,
   analog_loop,
   line_loop,
   payload_loop,
   diagnostic_loop,
   general_pin_one,
   general_pin_one_oe_b,
   general_pin_two,
   general_pin_two_oe_b
);
   input  wire                    core_clk;
   input  wire                    rst_b;
   input  wire [`LPC_AW-1:0]      reg_addr;
   input  wire [`LPC_DW-1:0]      reg_wdata;
   input  wire                    reg_wr;
   input  wire                    reg_rd;
   output reg  [`LPC_DW-1:0]      reg_rdata;
   input  wire                    rx_gated_clock;
   input  wire                    rx_clock_output;
   input  wire                    rx_data_enable;
   input  wire                    rx_start_of_frame_out;
   input  wire                    tx_gated_clock;
   input  wire                    tx_clock_output;
   input  wire                    tx_data_enable;
   input  wire                    tx_start_of_frame_out;
   input  wire                    rx_framer_ref;
   input  wire                    tx_framer_ref;
   input  wire                    global_ref_8k;
   input  wire                    rx_line_clock_pin;
   input  wire                    liu_recovered_clk;
   input  wire                    liu_enabled;
   input  wire                    clock_rate_adapter;
   input  wire                    tx_clock_input_pin;
   input  wire [`LPC_AL_W-1:0]    alarm_status;
   input  wire                    general_pin_one_en;
   input  wire                    general_pin_two_en;
   output reg  [2:0]              framing_select;
   output reg                     framing_undefined;
   output reg                     rx_clk_pin;
   output reg                     rx_frame_pin;
   output reg                     tx_clk_pin;
   output reg                     tx_frame_pin;
   output reg                     port_ref_8k;
   output reg                     port_ref_valid;
   output reg                     chip_ref_candidate;
   output reg                     timer_ref_8k;
   output reg  [1:0]              tx_clk_source;
   output reg                     tx_internal_clk;
   output reg                     rx_framer_io_timing;
   output reg                     tx_framer_io_timing;
   output reg                     tx_line_io_timing;
   output reg                     analog_loop;
   output reg                     line_loop;
   output reg                     payload_loop;
   output reg                     diagnostic_loop;
   output reg                     general_pin_one;
   output reg                     general_pin_one_oe_b;
   output reg                     general_pin_two;
   output reg                     general_pin_two_oe_b;

   // =======================================================
   // Alarm selection
   function alarm_pick;
      input [3:0]           sel;
      input [`LPC_AL_W-1:0] al;
      begin
         case (sel)
            4'h0: alarm_pick = al[`LPC_AL_LOS];
            4'h1: alarm_pick = al[`LPC_AL_OOF];
            4'h2: alarm_pick = al[`LPC_AL_LOF];
            4'h3: alarm_pick = al[`LPC_AL_AIS];
            4'h4: alarm_pick = al[`LPC_AL_RAI];
            4'h5: alarm_pick = al[`LPC_AL_IDLE];
            4'hB: alarm_pick = al[`LPC_AL_LOS] |
                               al[`LPC_AL_LOF] |
                               al[`LPC_AL_AIS];
            4'hD: alarm_pick = al[`LPC_AL_LOS] |
                               al[`LPC_AL_LOF] |
                               al[`LPC_AL_AIS];
            4'hE: alarm_pick = al[`LPC_AL_RAI] |
                               al[`LPC_AL_IDLE];
            4'hF: alarm_pick = |al;
            // Unassigned codes hold the pin low
            default: alarm_pick = 1'b0;
         endcase
      end
   endfunction

   // =======================================================
   // Register file
   reg  [`LPC_DW-1:0] framing_q;
   reg  [`LPC_DW-1:0] clk_timing_q;
   reg  [`LPC_DW-1:0] loop_alarm_q;
   reg  [`LPC_DW-1:0] rdata_d;

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         framing_q    <= `LPC_RESET_VALUE;
         clk_timing_q <= `LPC_RESET_VALUE;
         loop_alarm_q <= `LPC_RESET_VALUE;
      end else if (reg_wr) begin
         case (reg_addr)
            `LPC_ADDR_FRAMING:
               framing_q <= reg_wdata & `LPC_MASK_FRAMING;
            `LPC_ADDR_CLK_TIMING:
               clk_timing_q <= reg_wdata &
                               `LPC_MASK_CLK_TIMING;
            `LPC_ADDR_LOOP_ALARM:
               loop_alarm_q <= reg_wdata &
                               `LPC_MASK_LOOP_ALARM;
            default: framing_q <= framing_q;
         endcase
      end
   end

   // Stored values are already masked, so reserved bits read zero
   always @* begin
      rdata_d = `LPC_READ_IDLE;
      if (reg_rd) begin
         case (reg_addr)
            `LPC_ADDR_FRAMING:    rdata_d = framing_q;
            `LPC_ADDR_CLK_TIMING: rdata_d = clk_timing_q;
            `LPC_ADDR_LOOP_ALARM: rdata_d = loop_alarm_q;
            default:              rdata_d = `LPC_READ_IDLE;
         endcase
      end
   end

   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         reg_rdata <= `LPC_READ_IDLE;
      else
         reg_rdata <= rdata_d;
   end

   // =======================================================
   // Field views
   wire [2:0] fm_w   = framing_q[`LPC_FM_HI:`LPC_FM_LO];
   wire [1:0] ref_w  = clk_timing_q[`LPC_REF_SRC_HI:`LPC_REF_SRC_LO];
   wire [2:0] lbm_w  = loop_alarm_q[`LPC_LBM_HI:`LPC_LBM_LO];
   wire [3:0] gpa_w  = loop_alarm_q[`LPC_GPA_HI:`LPC_GPA_LO];
   wire [3:0] gpb_w  = loop_alarm_q[`LPC_GPB_HI:`LPC_GPB_LO];
   wire       loop_timing_enable_w = clk_timing_q[`LPC_LOOP_TIME];
   wire       clock_rate_adapter_dis_w = clk_timing_q[`LPC_CLOCK_RATE_ADAPTER_DIS];

   // =======================================================
   // Combinational selections
   reg        port_ref_d;
   reg        ref_valid_d;
   reg        fm_undef_d;
   reg  [3:0] loops_d;
   reg  [1:0] tx_src_d;
   reg        tx_clk_d;

   always @* begin
      fm_undef_d = 1'b0;
      case (fm_w)
         `LPC_FM_UNDEF_A: fm_undef_d = 1'b1;
         `LPC_FM_UNDEF_B: fm_undef_d = 1'b1;
         default:         fm_undef_d = 1'b0;
      endcase
   end

   // Undefined source codes give a quiet, flagged reference
   always @* begin
      port_ref_d  = 1'b0;
      ref_valid_d = 1'b0;
      case (ref_w)
         `LPC_REF_RX_FRAMER: begin
            port_ref_d  = rx_framer_ref;
            ref_valid_d = 1'b1;
         end
         `LPC_REF_TX_FRAMER: begin
            port_ref_d  = tx_framer_ref;
            ref_valid_d = 1'b1;
         end
         default: begin
            port_ref_d  = 1'b0;
            ref_valid_d = 1'b0;
         end
      endcase
   end

   // Order: analog, line, payload, diagnostic
   always @* begin
      case (lbm_w)
         `LPC_LB_NONE:      loops_d = 4'h0;
         `LPC_LB_ANALOG:    loops_d = 4'h8;
         `LPC_LB_LINE:      loops_d = 4'h4;
         `LPC_LB_PAYLOAD:   loops_d = 4'h2;
         `LPC_LB_DIAG_A:    loops_d = 4'h1;
         `LPC_LB_DIAG_B:    loops_d = 4'h1;
         `LPC_LB_LINE_DIAG: loops_d = 4'h5;
         `LPC_LB_DIAG_C:    loops_d = 4'h1;
         default:           loops_d = 4'h0;
      endcase
   end

   // Loop timing wins; the recovered clock is only usable while
   // the line interface runs, otherwise the raw line clock pin.
   // A loopback keeps transmit on the receive clock only while the rate adapter is disabled.
   always @* begin
      if (loop_timing_enable_w) begin
         if (liu_enabled)
            tx_src_d = `LPC_TXSRC_RECOVER;
         else
            tx_src_d = `LPC_TXSRC_RX_LINE;
      end else if (!clock_rate_adapter_dis_w) begin
         tx_src_d = `LPC_TXSRC_CLOCK_RATE_ADAPTER;
      end else if (lbm_w != `LPC_LB_NONE) begin
         tx_src_d = `LPC_TXSRC_RX_LINE;
      end else begin
         tx_src_d = `LPC_TXSRC_PIN;
      end
   end

   always @* begin
      case (tx_src_d)
         `LPC_TXSRC_RECOVER: tx_clk_d = liu_recovered_clk;
         `LPC_TXSRC_RX_LINE: tx_clk_d = rx_line_clock_pin;
         `LPC_TXSRC_CLOCK_RATE_ADAPTER:    tx_clk_d = clock_rate_adapter;
         default:            tx_clk_d = tx_clock_input_pin;
      endcase
   end

   // =======================================================
   // Registered outputs: one clock of latency on every path
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         framing_select      <= `LPC_FM_DS3_CBIT;
         framing_undefined   <= 1'b0;
         rx_clk_pin          <= 1'b0;
         rx_frame_pin        <= 1'b0;
         tx_clk_pin          <= 1'b0;
         tx_frame_pin        <= 1'b0;
         port_ref_8k         <= 1'b0;
         port_ref_valid      <= 1'b0;
         chip_ref_candidate  <= 1'b0;
         timer_ref_8k        <= 1'b0;
         tx_clk_source       <= `LPC_TXSRC_PIN;
         tx_internal_clk     <= 1'b0;
         rx_framer_io_timing <= 1'b0;
         tx_framer_io_timing <= 1'b0;
         tx_line_io_timing   <= 1'b0;
         analog_loop         <= 1'b0;
         line_loop           <= 1'b0;
         payload_loop        <= 1'b0;
         diagnostic_loop     <= 1'b0;
      end else begin
         framing_select    <= fm_w;
         framing_undefined <= fm_undef_d;
         rx_clk_pin <= clk_timing_q[`LPC_RX_CLK_SEL] ?
                       rx_clock_output : rx_gated_clock;
         rx_frame_pin <= clk_timing_q[`LPC_RX_FRM_SEL] ?
                 rx_start_of_frame_out : rx_data_enable;
         tx_clk_pin <= clk_timing_q[`LPC_TX_CLK_SEL] ?
                       tx_clock_output : tx_gated_clock;
         tx_frame_pin <= clk_timing_q[`LPC_TX_FRM_SEL] ?
                 tx_start_of_frame_out : tx_data_enable;
         port_ref_8k        <= port_ref_d;
         port_ref_valid     <= ref_valid_d;
         chip_ref_candidate <= port_ref_d;
         timer_ref_8k <= clk_timing_q[`LPC_TIMER_REF] ?
                         port_ref_d : global_ref_8k;
         tx_clk_source   <= tx_src_d;
         tx_internal_clk <= tx_clk_d;
         rx_framer_io_timing <=
            clk_timing_q[`LPC_RX_FR_TIMING];
         tx_framer_io_timing <=
            clk_timing_q[`LPC_TX_FR_TIMING];
         tx_line_io_timing <=
            clk_timing_q[`LPC_TX_LN_TIMING];
         analog_loop     <= loops_d[3];
         line_loop       <= loops_d[2];
         payload_loop    <= loops_d[1];
         diagnostic_loop <= loops_d[0];
      end
   end

   // =======================================================
   // General-purpose alarm pins; the pin stays released until
   // software enables it in the global pin control
   wire [1:0] gp_sel_en = {general_pin_two_en, general_pin_one_en};
   wire [7:0] gp_sel    = {gpb_w, gpa_w};
   reg  [1:0] gp_val_q;
   reg  [1:0] gp_oe_b_q;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_gp
         always @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               gp_val_q[gi]  <= 1'b0;
               gp_oe_b_q[gi] <= 1'b1;
            end else begin
               gp_val_q[gi] <= gp_sel_en[gi] &
                  alarm_pick(gp_sel[gi*4 +: 4],
                             alarm_status);
               gp_oe_b_q[gi] <= ~gp_sel_en[gi];
            end
         end
      end
   endgenerate

   always @* begin
      general_pin_one      = gp_val_q[0];
      general_pin_one_oe_b = gp_oe_b_q[0];
      general_pin_two      = gp_val_q[1];
      general_pin_two_oe_b = gp_oe_b_q[1];
   end

endmodule // lpc_port_cfg

// ---- test/lpc_port_cfg_sva.sv ----
`timescale 1ns/1ps
`include "lpc_defs.vh"

module lpc_port_cfg_sva (
   input logic        core_clk,
   input logic        rst_b,
   input logic [7:0]  reg_addr,
   input logic [15:0] reg_wdata,
   input logic [15:0] reg_rdata,
   input logic        reg_wr,
   input logic        reg_rd,
   input logic        rx_gated_clock,
   input logic        rx_clock_output,
   input logic        tx_data_enable,
   input logic        tx_start_of_frame_out,
   input logic        rx_framer_ref,
   input logic        tx_framer_ref,
   input logic        global_ref_8k,
   input logic        liu_enabled,
   input logic        general_pin_one_en,
   input logic        framing_undefined,
   input logic        rx_clk_pin,
   input logic        tx_frame_pin,
   input logic        port_ref_8k,
   input logic        chip_ref_candidate,
   input logic        timer_ref_8k,
   input logic        rx_framer_io_timing,
   input logic        tx_framer_io_timing,
   input logic        tx_line_io_timing,
   input logic        analog_loop,
   input logic        line_loop,
   input logic        payload_loop,
   input logic        diagnostic_loop,
   input logic        general_pin_one,
   input logic        general_pin_one_oe_b,
   input logic [2:0]  framing_select,
   input logic [1:0]  tx_clk_source
);
   // ==========================================================
   // Shadow of the writable bits, seen only through bus writes
   logic [15:0] cr3_q;
   logic [15:0] cr4_q;
   logic [2:0]  fm_q;
   logic        up_q;

   // up_q skips the first edge after reset, where $past sees reset values
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cr3_q <= 16'h0000;
         cr4_q <= 16'h0000;
         fm_q  <= 3'h0;
         up_q  <= 1'b0;
      end else begin
         up_q <= 1'b1;
         if (reg_wr && reg_addr == `LPC_ADDR_CLK_TIMING) begin
            cr3_q <= reg_wdata & `LPC_MASK_CLK_TIMING;
         end
         if (reg_wr && reg_addr == `LPC_ADDR_LOOP_ALARM) begin
            cr4_q <= reg_wdata & `LPC_MASK_LOOP_ALARM;
         end
         if (reg_wr && reg_addr == `LPC_ADDR_FRAMING) begin
            fm_q <= reg_wdata[5:3];
         end
      end
   end

   function automatic logic [3:0] lb_dec(input logic [2:0] c);
      case (c)
         3'h0: lb_dec = 4'h0;
         3'h1: lb_dec = 4'h8;
         3'h2: lb_dec = 4'h4;
         3'h3: lb_dec = 4'h2;
         3'h6: lb_dec = 4'h5;
         default: lb_dec = 4'h1;
      endcase
   endfunction

   // ==========================================================
   // Properties
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_rd_cr3;
      reg_rd && reg_addr == `LPC_ADDR_CLK_TIMING;
   endsequence

   a_read_back: assert property (s_rd_cr3 |=> reg_rdata == cr3_q)
      else $error("read data differs from written value");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside read cycle");
   a_rx_clk_mux: assert property (up_q |-> rx_clk_pin ==
      ($past(cr3_q[13]) ? $past(rx_clock_output) : $past(rx_gated_clock)))
      else $error("receive clock pin wrong source");
   a_tx_frm_mux: assert property (up_q |-> tx_frame_pin ==
      ($past(cr3_q[9]) ? $past(tx_start_of_frame_out) : $past(tx_data_enable)))
      else $error("transmit frame pin wrong source");
   a_port_ref: assert property (up_q |->
      chip_ref_candidate == port_ref_8k
      && port_ref_8k == ($past(cr3_q[7:6]) == 2'h2 ? $past(rx_framer_ref)
      : $past(cr3_q[7:6]) == 2'h3 && $past(tx_framer_ref)))
      else $error("port reference wrong");
   a_timer_ref: assert property (up_q |-> timer_ref_8k ==
      ($past(cr3_q[5]) ? port_ref_8k : $past(global_ref_8k)))
      else $error("timer reference wrong");
   a_loop_dec: assert property (up_q |-> {analog_loop, line_loop,
      payload_loop, diagnostic_loop} == lb_dec($past(cr4_q[10:8])))
      else $error("loopback decode wrong");
   a_io_timing: assert property (up_q |->
      {rx_framer_io_timing,
      tx_framer_io_timing, tx_line_io_timing} == $past(cr3_q[2:0]))
      else $error("timing select wrong");
   a_loop_time: assert property (up_q && $past(cr3_q[4]) |->
      tx_clk_source == ($past(liu_enabled) ? 2'h2 : 2'h1))
      else $error("loop timing source wrong");
   a_clock_rate_adapter_off: assert property (up_q && $past(cr3_q[4:3]) == 2'h1
      && $past(cr4_q[10:8]) == 3'h0 |-> tx_clk_source == 2'h0)
      else $error("transmit pin not chosen");
   a_pin_gate: assert property (up_q && !$past(general_pin_one_en) |->
      !general_pin_one && general_pin_one_oe_b)
      else $error("first general pin driven while disabled");
   a_framing_code: assert property (up_q |->
      framing_select == $past(fm_q) && framing_undefined ==
      ($past(fm_q) == 3'h5 || $past(fm_q) == 3'h7))
      else $error("framing select wrong");
endmodule // lpc_port_cfg_sva

bind lpc_port_cfg lpc_port_cfg_sva i_sva (.*);

// ---- test/tb.sv ----
`timescale 1ns/1ps
`include "lpc_defs.vh"

module tb;
   // ==========================================================
   // Stimulus and observation
   logic        core_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [23:0] stim = 24'h000000;
   logic [15:0] d;
   logic [15:0] e;
   logic        p;
   wire  [15:0] reg_rdata;
   wire  [5:0]  alarm_status;
   wire  [2:0]  framing_select;
   wire  [1:0]  tx_clk_source;
   wire rx_gated_clock, rx_clock_output, rx_data_enable, rx_start_of_frame_out;
   wire tx_gated_clock, tx_clock_output, tx_data_enable, tx_start_of_frame_out;
   wire rx_framer_ref, tx_framer_ref, global_ref_8k, rx_line_clock_pin;
   wire liu_recovered_clk, liu_enabled, clock_rate_adapter, tx_clock_input_pin;
   wire general_pin_one_en, general_pin_two_en, framing_undefined, rx_clk_pin;
   wire rx_frame_pin, tx_clk_pin, tx_frame_pin, port_ref_8k, port_ref_valid;
   wire chip_ref_candidate, timer_ref_8k, tx_internal_clk, rx_framer_io_timing;
   wire tx_framer_io_timing, tx_line_io_timing, analog_loop, line_loop;
   wire payload_loop, diagnostic_loop, general_pin_one, general_pin_one_oe_b;
   wire general_pin_two, general_pin_two_oe_b;
   int  miscompares = 0;
   int  n_checks = 0;
   // Rows: address, write data, expected decode nibble
   logic [27:0] rows [16] = '{28'h42FFC70, 28'h4200081, 28'h4200102,
      28'h4200183, 28'h4200204, 28'h420028D, 28'h4200306, 28'h42FFFFF,
      28'h4600000, 28'h4601008, 28'h4602004, 28'h4603002, 28'h4604001,
      28'h4605001, 28'h4606005, 28'h46FFFF1};
   // Transmit clock cases: config 3, config 4, line unit on, source
   logic [35:0] ts [5] = '{36'h00100000A, 36'h001000001, 36'h000000003,
      36'h000800000, 36'h000802001};

   always #12.5 core_clk = ~core_clk;

   assign {rx_gated_clock, rx_clock_output, rx_data_enable,
      rx_start_of_frame_out, tx_gated_clock, tx_clock_output, tx_data_enable,
      tx_start_of_frame_out, rx_framer_ref, tx_framer_ref, global_ref_8k,
      rx_line_clock_pin, liu_recovered_clk, liu_enabled, clock_rate_adapter,
      tx_clock_input_pin, general_pin_one_en, general_pin_two_en,
      alarm_status} = stim;
   wire [3:0] pins = {rx_clk_pin, rx_frame_pin, tx_clk_pin, tx_frame_pin};
   wire [3:0] refs = {port_ref_8k, chip_ref_candidate, port_ref_valid,
      timer_ref_8k};
   wire [3:0] gp = {general_pin_one, general_pin_one_oe_b, general_pin_two,
      general_pin_two_oe_b};

   lpc_port_cfg i_dut (.*);

   // ==========================================================
   // Bus and check tasks
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic cfg(input logic [15:0] c3, c4, input logic [23:0] s);
      wr(`LPC_ADDR_CLK_TIMING, c3);
      wr(`LPC_ADDR_LOOP_ALARM, c4);
      stim <= s;
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Sequence
   initial begin
      repeat (5) @(posedge core_clk);
      #1;
      chk("pins in reset", 16'(gp), 16'h0005);
      rst_b <= 1'b1;
      @(posedge core_clk);
      #1;
      for (int a = 8'h42; a <= 8'h48; a += 2) begin
         rd(8'(a));
         chk("reset value", d, 16'h0000);
      end
      foreach (rows[i]) begin
         wr(rows[i][27:20], rows[i][19:4]);
         rd(rows[i][27:20]);
         e = rows[i][22] ? `LPC_MASK_LOOP_ALARM : `LPC_MASK_FRAMING;
         chk("readback", d, rows[i][19:4] & e);
         repeat (2) @(posedge core_clk);
         #1;
         e = rows[i][22] ? 16'({analog_loop, line_loop, payload_loop,
            diagnostic_loop}) : 16'({framing_undefined, framing_select});
         chk("decode", e, 16'(rows[i][3:0]));
      end
      // Unmapped write then read with no gap, and reserved bits dropped
      wr(8'h48, 16'hFFFF);
      rd(8'h48);
      chk("unmapped", d, 16'h0000);
      wr(`LPC_ADDR_CLK_TIMING, 16'hFFFF);
      rd(`LPC_ADDR_CLK_TIMING);
      chk("reserved", d, 16'h36FF);
      for (int i = 0; i < 4; i++) begin
         cfg(i[1] ? 16'h3605 : 16'h0000, 16'h0000,
             {i[0] ? 8'h55 : 8'hAA, 16'h0000});
         chk("pin mux", 16'(pins),
             (i[0] ^ i[1]) ? 16'h0000 : 16'h000F);
         e = 16'({rx_framer_io_timing, tx_framer_io_timing,
            tx_line_io_timing});
         chk("io timing", e,
             i[1] ? 16'h0005 : 16'h0000);
      end
      for (int k = 0; k < 2; k++) begin
         for (int c = 0; c < 8; c++) begin
            cfg(16'(c << 5), 16'h0000, k ? 24'h006000 : 24'h008000);
            p = (c[2:1] == 2 + k);
            e = 16'({p, p, c[2], c[0] ? p : k[0]});
            chk("port reference", 16'(refs), e);
         end
      end
      foreach (ts[j]) begin
         cfg(ts[j][35:20], ts[j][19:4], {12'h001, 1'b0, ts[j][3], 10'h100});
         // Of the clock inputs, only the transmit pin and the line clock pin are driven high
         e = 16'({ts[j][1:0], ~ts[j][1]});
         chk("tx clock", 16'({tx_clk_source, tx_internal_clk}),
             e);
      end
      for (int g = 0; g < 16; g++) begin
         cfg(16'h0000, 16'(g * 17), 24'h0000CC);
         p = 1'(16'hA80C >> g);
         chk("alarm pins", 16'(gp), 16'({p, 1'b0, p, 1'b0}));
      end
      cfg(16'h0000, 16'h0022, 24'h00004C);
      chk("pin disabled", 16'(gp), 16'h0006);
      // Second reset in mid-run must clear the settings again
      rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      #1;
      rd(`LPC_ADDR_LOOP_ALARM);
      chk("mid-run reset", d, 16'h0000);
      // Second pin still enabled, its select back on line loss
      chk("reset pins", 16'(gp), 16'h0004);
      print_verdict;
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      miscompares++;
      print_verdict;
   end
endmodule // tb
